// ==== sosc_defines.svh ====
// Constants of the sensor output control block: offsets, fields, timing
`ifndef SOSC_DEFINES_SVH
`define SOSC_DEFINES_SVH
`define SOSC_CLK_MHZ 200
// Register offsets
`define SOSC_ADDR_CONFIG 8'h07
`define SOSC_ADDR_CONTROL 8'h08
`define SOSC_ADDR_ENTRY 8'h2A
`define SOSC_ADDR_CONFIRM 8'h36
// Keys
`define SOSC_ENTRY_KEY 8'h3C
`define SOSC_CONFIRM_KEY 8'h96
// Field positions and reset values
`define SOSC_BIT_BYPASS_SEL 0
`define SOSC_RST_CONFIG 8'h00
`define SOSC_RST_BYPASS_SEL 1'b1
// Times in their own units
`define SOSC_DET_US 120
`define SOSC_RETRY_OFF_MS 4
`define SOSC_STRETCH_MS 4
`define SOSC_BLINK_MS 500
`define SOSC_DLY0_MS 50
`define SOSC_DLY1_MS 100
`define SOSC_DLY2_MS 200
`define SOSC_DLY3_MS 300
// Derived cycle counts
`define SOSC_US2CYC(t) ((t) * `SOSC_CLK_MHZ)
`define SOSC_MS2CYC(t) ((t) * 1000 * `SOSC_CLK_MHZ)
`endif

// ==== sosc_pkg.sv ====
// Types shared by the sensor output control block
`default_nettype none
package sosc_pkg;
	// Configuration image layout, bit 7 unused
	typedef struct packed {
		logic unused;
		logic regulator_high_select;
		logic [1:0] startup_delay_select;
		logic open_contact;
		logic push_pull_type;
		logic low_side;
		logic stretch_enable;
	} sosc_cfg_type;
	// Driver stage commands
	typedef struct packed {
		logic drive_supply;
		logic drive_ground;
	} sosc_drive_type;
	typedef enum logic [2:0] {
		ST_STARTUP = 3'b001,
		ST_RUN = 3'b010,
		ST_BLINK = 3'b100
	} sosc_mode_type;
	typedef enum logic [2:0] {
		AR_NORMAL = 3'b001,
		AR_OFF = 3'b010,
		AR_PROBE = 3'b100
	} sosc_retry_type;
endpackage : sosc_pkg
`default_nettype wire

// ==== sosc_out_map.sv ====
// Maps the sensor state to driver and indicator commands
`default_nettype none
module sosc_out_map (
	input wire logic i_in_a,
	input wire logic i_in_b,
	input wire sosc_pkg::sosc_cfg_type i_cfg,
	output sosc_pkg::sosc_drive_type o_drive,
	output logic o_ind_a,
	output logic o_ind_b
);
	logic active;
	// Contact logic decides the active level, type decides the stage
	always_comb
	begin
		active = i_cfg.open_contact ? i_in_a : ~i_in_a;
		o_ind_a = active;
		o_ind_b = i_in_b;
		if (i_cfg.push_pull_type)
		begin
			o_drive.drive_supply = active;
			o_drive.drive_ground = ~active;
		end
		else if (i_cfg.low_side)
		begin
			o_drive.drive_supply = 1'b0;
			o_drive.drive_ground = active;
		end
		else
		begin
			o_drive.drive_supply = active;
			o_drive.drive_ground = 1'b0;
		end
	end
endmodule : sosc_out_map
`default_nettype wire

// ==== sosc_ctrl.sv ====
// Sensor output driver control: mapping, protection, programming keys
`include "sosc_defines.svh"
`default_nettype none
module sosc_ctrl #(
	parameter int unsigned DET_CYC = `SOSC_US2CYC(`SOSC_DET_US),
	parameter int unsigned OFF_CYC = `SOSC_MS2CYC(`SOSC_RETRY_OFF_MS),
	parameter int unsigned STRETCH_CYC = `SOSC_MS2CYC(`SOSC_STRETCH_MS),
	parameter int unsigned BLINK_CYC = `SOSC_MS2CYC(`SOSC_BLINK_MS),
	parameter int unsigned DLY0_CYC = `SOSC_MS2CYC(`SOSC_DLY0_MS),
	parameter int unsigned DLY1_CYC = `SOSC_MS2CYC(`SOSC_DLY1_MS),
	parameter int unsigned DLY2_CYC = `SOSC_MS2CYC(`SOSC_DLY2_MS),
	parameter int unsigned DLY3_CYC = `SOSC_MS2CYC(`SOSC_DLY3_MS)
) (
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire logic i_sensor_input_a,
	input wire logic i_sensor_input_b,
	input wire logic i_short_detect,
	input wire logic i_over_temp,
	input wire logic i_fuse_programmed,
	input wire sosc_pkg::sosc_cfg_type i_fuse_image,
	input wire logic i_fuse_error,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	output logic o_prog_mode,
	output logic o_drive_supply,
	output logic o_drive_ground,
	output logic o_indicator_a,
	output logic o_indicator_b,
	output logic o_regulator_on,
	output logic o_regulator_high_select
);
	////////////////////////////////////////////////////////////////////
	// Pin synchronisers: A, B, short, over-temperature
	logic [3:0] sync1_r;
	logic [3:0] sync2_r;
	logic in_a;
	logic in_b;
	logic short_s;
	logic hot_s;
	always_ff @(posedge i_sys_clk)
	begin
		sync1_r <= {i_over_temp, i_short_detect, i_sensor_input_b,
			i_sensor_input_a};
		sync2_r <= sync1_r;
	end
	assign {hot_s, short_s, in_b, in_a} = sync2_r;

	////////////////////////////////////////////////////////////////////
	// Register file and programming keys. Writes arrive already decoded
	// by the standard-speed single-wire transport; overdrive is never
	// accepted there.
	sosc_pkg::sosc_cfg_type cfg_img_r, cfg_img_nxt;
	sosc_pkg::sosc_cfg_type trial_cfg_r, trial_cfg_nxt;
	logic bypass_sel_r, bypass_sel_nxt;
	logic armed_r, armed_nxt;
	logic prog_r, prog_nxt;
	logic trial_r, trial_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic wr_cfg, wr_ctl, wr_entry, wr_conf;
	always_comb
	begin
		wr_cfg = i_reg_wr && i_reg_addr == `SOSC_ADDR_CONFIG;
		wr_ctl = i_reg_wr && i_reg_addr == `SOSC_ADDR_CONTROL;
		wr_entry = i_reg_wr && i_reg_addr == `SOSC_ADDR_ENTRY;
		wr_conf = i_reg_wr && i_reg_addr == `SOSC_ADDR_CONFIRM;
		cfg_img_nxt = cfg_img_r;
		bypass_sel_nxt = bypass_sel_r;
		armed_nxt = armed_r;
		prog_nxt = prog_r;
		trial_nxt = trial_r;
		trial_cfg_nxt = trial_cfg_r;
		rdata_nxt = rdata_r;
		// Fused parts ignore image and select writes entirely
		if (wr_cfg && prog_r && !i_fuse_programmed)
			cfg_img_nxt = i_reg_wdata;
		if (wr_ctl && prog_r && !i_fuse_programmed)
			bypass_sel_nxt = i_reg_wdata[`SOSC_BIT_BYPASS_SEL];
		if (wr_entry)
			armed_nxt = i_reg_wdata == `SOSC_ENTRY_KEY;
		if (wr_conf)
		begin
			armed_nxt = 1'b0;
			if (i_reg_wdata == `SOSC_CONFIRM_KEY)
				prog_nxt = armed_r || prog_r;
			else
			begin
				prog_nxt = 1'b0;
				// Leaving with cells transparent commits the trial
				if (prog_r && !bypass_sel_r && !i_fuse_programmed)
				begin
					trial_nxt = 1'b1;
					trial_cfg_nxt = cfg_img_r;
				end
			end
		end
		// Unmapped or write-only offsets read as zero
		if (i_reg_rd)
		begin
			if (i_reg_addr == `SOSC_ADDR_CONFIG)
				rdata_nxt = cfg_img_r;
			else if (i_reg_addr == `SOSC_ADDR_CONTROL)
				rdata_nxt = {7'h00, bypass_sel_r};
			else if (i_reg_addr == `SOSC_ADDR_CONFIRM)
				rdata_nxt = {7'h00, prog_r};
			else
				rdata_nxt = 8'h00;
		end
	end
	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
		begin
			cfg_img_r <= `SOSC_RST_CONFIG;
			trial_cfg_r <= `SOSC_RST_CONFIG;
			bypass_sel_r <= `SOSC_RST_BYPASS_SEL;
			armed_r <= 1'b0;
			prog_r <= 1'b0;
			trial_r <= 1'b0;
			rdata_r <= 8'h00;
		end
		else
		begin
			cfg_img_r <= cfg_img_nxt;
			trial_cfg_r <= trial_cfg_nxt;
			bypass_sel_r <= bypass_sel_nxt;
			armed_r <= armed_nxt;
			prog_r <= prog_nxt;
			trial_r <= trial_nxt;
			rdata_r <= rdata_nxt;
		end
	end
	assign o_reg_rdata = rdata_r;
	assign o_prog_mode = prog_r;

	////////////////////////////////////////////////////////////////////
	// Active configuration: trial wins over fuses until reset
	sosc_pkg::sosc_cfg_type cfg;
	logic unprog, safe, quiet;
	assign cfg = trial_r ? trial_cfg_r : i_fuse_image;
	assign unprog = !i_fuse_programmed && !trial_r;
	assign safe = i_fuse_error && i_fuse_programmed;

	// Delay select to cycle count
	function automatic logic [31:0] delay_cycles(input logic [1:0] sel);
		case (sel)
			2'h0: delay_cycles = 32'(DLY0_CYC);
			2'h1: delay_cycles = 32'(DLY1_CYC);
			2'h2: delay_cycles = 32'(DLY2_CYC);
			default: delay_cycles = 32'(DLY3_CYC);
		endcase
	endfunction : delay_cycles

	////////////////////////////////////////////////////////////////////
	// Mode machine with startup and blink timers, one clock base
	sosc_pkg::sosc_mode_type mode_r, mode_nxt;
	logic [31:0] mcnt_r, mcnt_nxt;
	logic phase_r, phase_nxt;
	always_comb
	begin
		mode_nxt = mode_r;
		mcnt_nxt = mcnt_r + 32'h1;
		phase_nxt = phase_r;
		case (mode_r)
			sosc_pkg::ST_STARTUP:
			begin
				if (mcnt_r + 32'h1 >= delay_cycles(cfg.startup_delay_select))
				begin
					mcnt_nxt = 32'h0;
					mode_nxt = sosc_pkg::ST_RUN;
				end
			end
			sosc_pkg::ST_RUN:
			begin
				mcnt_nxt = 32'h0;
				if (unprog || safe)
					mode_nxt = sosc_pkg::ST_BLINK;
			end
			sosc_pkg::ST_BLINK:
			begin
				// Toggle every half second
				if (mcnt_r + 32'h1 >= 32'(BLINK_CYC))
				begin
					mcnt_nxt = 32'h0;
					phase_nxt = ~phase_r;
				end
				if (!unprog && !safe)
					mode_nxt = sosc_pkg::ST_RUN;
			end
			default:
				mode_nxt = sosc_pkg::ST_STARTUP;
		endcase
	end
	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
		begin
			mode_r <= sosc_pkg::ST_STARTUP;
			mcnt_r <= 32'h0;
			phase_r <= 1'b0;
		end
		else
		begin
			mode_r <= mode_nxt;
			mcnt_r <= mcnt_nxt;
			phase_r <= phase_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Pulse stretch on input A; timer restarts on each rising edge
	logic a_d_r, a_d_nxt;
	logic [31:0] st_cnt_r, st_cnt_nxt;
	logic a_eff;
	always_comb
	begin
		a_d_nxt = in_a;
		st_cnt_nxt = st_cnt_r;
		if (in_a && !a_d_r && cfg.stretch_enable)
			st_cnt_nxt = 32'(STRETCH_CYC) - 32'h1;
		else if (st_cnt_r != 32'h0)
			st_cnt_nxt = st_cnt_r - 32'h1;
	end
	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
		begin
			a_d_r <= 1'b1; // A already high at reset is no new pulse
			st_cnt_r <= 32'h0;
		end
		else
		begin
			a_d_r <= a_d_nxt;
			st_cnt_r <= st_cnt_nxt;
		end
	end
	// Low pulses pass untouched once the stretch has run out
	assign a_eff = in_a || (cfg.stretch_enable && st_cnt_r != 32'h0);

	sosc_pkg::sosc_drive_type map_drive;
	logic map_ind_a, map_ind_b;
	sosc_out_map u_map (
		.i_in_a(a_eff),
		.i_in_b(in_b),
		.i_cfg(cfg),
		.o_drive(map_drive),
		.o_ind_a(map_ind_a),
		.o_ind_b(map_ind_b)
	);
	logic driving;
	assign driving = map_drive.drive_supply || map_drive.drive_ground;

	////////////////////////////////////////////////////////////////////
	// Autoretry. Shorts shorter than the detection interval are never
	// seen, so fast toggling under a short is not limited.
	sosc_pkg::sosc_retry_type ar_r, ar_nxt;
	logic [31:0] ar_cnt_r, ar_cnt_nxt;
	always_comb
	begin
		ar_nxt = ar_r;
		ar_cnt_nxt = 32'h0;
		case (ar_r)
			sosc_pkg::AR_NORMAL:
			begin
				if (short_s && driving && o_drive_enable_q())
				begin
					ar_cnt_nxt = ar_cnt_r + 32'h1;
					if (ar_cnt_r + 32'h1 >= 32'(DET_CYC))
					begin
						ar_nxt = sosc_pkg::AR_OFF;
						ar_cnt_nxt = 32'h0;
					end
				end
			end
			sosc_pkg::AR_OFF:
			begin
				ar_cnt_nxt = ar_cnt_r + 32'h1;
				if (ar_cnt_r + 32'h1 >= 32'(OFF_CYC))
				begin
					ar_nxt = sosc_pkg::AR_PROBE;
					ar_cnt_nxt = 32'h0;
				end
			end
			sosc_pkg::AR_PROBE:
			begin
				if (!short_s)
					ar_nxt = sosc_pkg::AR_NORMAL;
				else if (ar_cnt_r + 32'h1 >= 32'(DET_CYC))
					ar_nxt = sosc_pkg::AR_OFF;
				else
					ar_cnt_nxt = ar_cnt_r + 32'h1;
			end
			default:
				ar_nxt = sosc_pkg::AR_NORMAL;
		endcase
	end
	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
		begin
			ar_r <= sosc_pkg::AR_NORMAL;
			ar_cnt_r <= 32'h0;
		end
		else
		begin
			ar_r <= ar_nxt;
			ar_cnt_r <= ar_cnt_nxt;
		end
	end

	// Output may be driven: running and cool
	function automatic logic o_drive_enable_q();
		o_drive_enable_q = mode_r == sosc_pkg::ST_RUN && !hot_s;
	endfunction : o_drive_enable_q

	////////////////////////////////////////////////////////////////////
	// Output registers; overrides sit above the mapping
	logic [5:0] out_r, out_nxt;
	always_comb
	begin
		quiet = hot_s || mode_r == sosc_pkg::ST_STARTUP;
		out_nxt[5] = !hot_s;
		out_nxt[4] = cfg.regulator_high_select && !unprog && !safe;
		if (quiet || unprog || safe || !o_drive_enable_q()
			|| ar_r == sosc_pkg::AR_OFF)
			out_nxt[3:2] = 2'b00;
		else
			out_nxt[3:2] = map_drive;
		if (quiet)
			out_nxt[1:0] = 2'b00;
		else if (unprog || safe)
			out_nxt[1:0] = {~phase_r, phase_r};
		else
			out_nxt[1:0] = {map_ind_b, map_ind_a};
	end
	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
			out_r <= 6'h00;
		else
			out_r <= out_nxt;
	end
	assign {o_regulator_on, o_regulator_high_select, o_drive_supply,
		o_drive_ground, o_indicator_b, o_indicator_a} = out_r;

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);
	logic drv_any;
	assign drv_any = o_drive_supply || o_drive_ground;
	hot_gate_a: assert property (hot_s |=> !drv_any && !o_regulator_on
		&& !o_indicator_a && !o_indicator_b)
		else $error("drivers active while over temperature");
	safe_hiz_a: assert property (safe |=> !drv_any
		&& !o_regulator_high_select)
		else $error("safe mode left output driven");
	retry_off_a: assert property (ar_r == sosc_pkg::AR_OFF |=> !drv_any)
		else $error("driver on during retry off period");
	trip_a: assert property (ar_r == sosc_pkg::AR_NORMAL && short_s
		&& driving && o_drive_enable_q() && ar_cnt_r == 32'(DET_CYC) - 1
		|=> ar_r == sosc_pkg::AR_OFF ##1 !drv_any)
		else $error("short not tripped after detection interval");
	arm_only_a: assert property (wr_entry && !prog_r
		&& i_reg_wdata == `SOSC_ENTRY_KEY |=> armed_r && !prog_r)
		else $error("entry key did not arm only");
	confirm_a: assert property (wr_conf && armed_r
		&& i_reg_wdata == `SOSC_CONFIRM_KEY |=> prog_r)
		else $error("confirm key did not enter programming");
	leave_a: assert property (wr_conf
		&& i_reg_wdata != `SOSC_CONFIRM_KEY |=> !prog_r)
		else $error("programming mode not left");
	locked_a: assert property (i_fuse_programmed |=> $stable(cfg_img_r))
		else $error("fused image changed");
	trial_a: assert property (wr_conf && prog_r && !bypass_sel_r
		&& !i_fuse_programmed && i_reg_wdata != `SOSC_CONFIRM_KEY
		|=> trial_r && trial_cfg_r == $past(cfg_img_r))
		else $error("trial configuration not latched");
	startup_a: assert property (mode_r == sosc_pkg::ST_STARTUP
		|=> !drv_any && !o_indicator_a && !o_indicator_b)
		else $error("active during startup delay");
	cov_trip_c: cover property (ar_r == sosc_pkg::AR_OFF
		##1 ar_r == sosc_pkg::AR_PROBE);
	cov_prog_c: cover property (armed_r ##1 prog_r);
	cov_trial_c: cover property ($rose(trial_r));
	cov_blink_c: cover property ($rose(phase_r));
endmodule : sosc_ctrl
`default_nettype wire

// ==== sosc_load_model.sv ====
// Load model: short-circuit sense behind the output driver
`default_nettype none
module sosc_load_model (
	input wire logic i_sys_clk,
	input wire logic i_drive_supply,
	input wire logic i_shorted,
	output logic o_short_detect
);
	timeunit 1ns;
	timeprecision 1ps;
	// Current only flows while the high side conducts, so the flag drops
	// as soon as the driver lets go; one cycle of comparator lag
	always_ff @(posedge i_sys_clk)
		o_short_detect <= i_shorted & i_drive_supply;
endmodule : sosc_load_model
`default_nettype wire

// ==== tb_sensor_output_control_otp.sv ====
// Self-checking bench of the sensor output driver control block
`default_nettype none
module tb_sensor_output_control_otp;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DET = 8;
	localparam int OFF = 20;
	localparam int STR = 16;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic in_a = 1'b0;
	logic in_b = 1'b0;
	logic shorted = 1'b0;
	logic hot = 1'b0;
	logic fused = 1'b0;
	logic ferr = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	sosc_pkg::sosc_cfg_type fimg = 8'h00;
	logic short_det;
	logic [7:0] rdata;
	logic pmode, sup, gnd, ia, ib, reg_on, reg_hi;
	int n_errors = 0;
	int checked = 0;
	logic [31:0] seed = 32'h8BD2;

	////////////////////////////////////////////////////////////////////////
	sosc_ctrl #(.DET_CYC(DET), .OFF_CYC(OFF), .STRETCH_CYC(STR),
		.BLINK_CYC(10), .DLY0_CYC(30), .DLY1_CYC(40), .DLY2_CYC(50),
		.DLY3_CYC(60)) uut (
		.i_sys_clk(clk), .i_srst(srst), .i_sensor_input_a(in_a),
		.i_sensor_input_b(in_b), .i_short_detect(short_det),
		.i_over_temp(hot), .i_fuse_programmed(fused),
		.i_fuse_image(fimg), .i_fuse_error(ferr), .i_reg_wr(wr),
		.i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
		.o_reg_rdata(rdata), .o_prog_mode(pmode), .o_drive_supply(sup),
		.o_drive_ground(gnd), .o_indicator_a(ia), .o_indicator_b(ib),
		.o_regulator_on(reg_on), .o_regulator_high_select(reg_hi));
	sosc_load_model load (.i_sys_clk(clk), .i_drive_supply(sup),
		.i_shorted(shorted), .o_short_detect(short_det));

	// 200 MHz system clock
	always #2.5 clk = ~clk;

	////////////////////////////////////////////////////////////////////////
	// Compare and count; unknowns never match
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("Error %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check

	task automatic test_done;
		if (n_errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done

	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction : xs

	// Expected {supply, ground, indicator a, indicator b}
	function automatic logic [3:0] exp_map(input sosc_pkg::sosc_cfg_type c,
		input int a, input int b);
		int act;
		act = c.open_contact ? a : 1 - a;
		if (c.push_pull_type)
			return {act[0], ~act[0], act[0], b[0]};
		return {act[0] & ~c.low_side, act[0] & c.low_side, act[0], b[0]};
	endfunction : exp_map

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : settle

	task automatic do_reset;
		@(posedge clk);
		srst <= 1'b1;
		repeat (20) @(posedge clk);
		srst <= 1'b0;
	endtask : do_reset

	// One byte per transfer at the standard pace, never faster
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] q);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		q = rdata;
	endtask : rd_reg

	task automatic set_in(input logic a, input logic b);
		@(posedge clk);
		in_a <= a;
		in_b <= b;
	endtask : set_in

	// Trial sequence: enter, write image, open the cells, leave
	task automatic trial(input sosc_pkg::sosc_cfg_type c);
		logic [7:0] r;
		wr_reg(8'h2A, 8'h3C);
		wr_reg(8'h36, 8'h96);
		settle(1);
		check("prog_mode_on", pmode, 1'b1);
		wr_reg(8'h07, c);
		rd_reg(8'h07, r);
		check("image_rd", r, c);
		wr_reg(8'h08, 8'h00);
		wr_reg(8'h36, 8'h00);
		settle(1);
		check("prog_mode_off", pmode, 1'b0);
	endtask : trial

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		sosc_pkg::sosc_cfg_type c;
		logic [7:0] r;
		int n;
		do_reset();
		for (int i = 0; i < 25; i++)
		begin
			@(negedge clk);
			check("startup", {sup, gnd, ia, ib}, 4'h0);
		end
		rd_reg(8'h08, r);
		check("control_rst", r, 8'h01);
		rd_reg(8'h07, r);
		check("image_rst", r, 8'h00);
		rd_reg(8'h55, r);
		check("unmapped", r, 8'h00);
		settle(40);
		n = 0;
		for (int i = 0; i < 40; i++)
		begin
			@(negedge clk);
			n += ia;
			check("blink_alt", ia ^ ib, 1'b1);
			check("released", {sup, gnd, reg_hi}, 3'h0);
		end
		check("blink_len", n, 20);
		wr_reg(8'h36, 8'h96);
		settle(1);
		check("no_arm", pmode, 1'b0);
		wr_reg(8'h2A, 8'h3C);
		settle(1);
		check("armed_only", pmode, 1'b0);
		// A wrong entry value disarms, so the key alone does nothing
		wr_reg(8'h2A, 8'h55);
		wr_reg(8'h36, 8'h96);
		settle(1);
		check("disarm", pmode, 1'b0);
		wr_reg(8'h2A, 8'h3C);
		wr_reg(8'h36, 8'h96);
		rd_reg(8'h36, r);
		check("confirm_rd", r, 8'h01);
		do_reset();
		settle(1);
		check("por_exit", pmode, 1'b0);
		// Every contact logic and output type, stretch off, other fields random
		for (int k = 0; k < 8; k++)
		begin
			seed = xs(seed);
			c = seed[7:0];
			c.unused = 1'b0;
			c.stretch_enable = 1'b0;
			c.open_contact = k[0];
			c.push_pull_type = k[1];
			c.low_side = k[2];
			do_reset();
			trial(c);
			settle(80);
			check("regulator", {reg_on, reg_hi},
				{1'b1, c.regulator_high_select});
			for (int j = 0; j < 4; j++)
			begin
				set_in(j[0], j[1]);
				settle(8);
				check("map", {sup, gnd, ia, ib}, exp_map(c, j & 1, j >> 1));
			end
		end
		// Stretch: short high pulse grows, short low pulse does not
		c = 8'h09;
		set_in(1'b0, 1'b0);
		do_reset();
		trial(c);
		settle(80);
		set_in(1'b1, 1'b0);
		repeat (3) @(posedge clk);
		in_a <= 1'b0;
		n = 0;
		for (int i = 0; i < 60; i++)
		begin
			@(negedge clk);
			n += sup;
		end
		check("stretch_hi", n, STR);
		set_in(1'b1, 1'b0);
		settle(30);
		@(posedge clk);
		in_a <= 1'b0;
		repeat (3) @(posedge clk);
		in_a <= 1'b1;
		n = 0;
		for (int i = 0; i < 30; i++)
		begin
			@(negedge clk);
			n += !sup;
		end
		check("stretch_lo", n, 3);
		// Short shorter than the detection interval is ignored
		@(posedge clk);
		shorted <= 1'b1;
		repeat (DET / 2) @(posedge clk);
		shorted <= 1'b0;
		settle(10);
		check("short_brief", sup, 1'b1);
		@(posedge clk);
		shorted <= 1'b1;
		n = 0;
		while (sup === 1'b1 && n < 50)
		begin
			@(negedge clk);
			n++;
		end
		check("trip", n >= DET && n <= DET + 6, 1'b1);
		n = 0;
		while (sup !== 1'b1 && n < 100)
		begin
			@(negedge clk);
			n++;
		end
		check("retry_off", n >= OFF && n <= OFF + 2, 1'b1);
		n = 0;
		while (sup === 1'b1 && n < 50)
		begin
			@(negedge clk);
			n++;
		end
		check("probe", n >= DET && n <= DET + 6, 1'b1);
		@(posedge clk);
		shorted <= 1'b0;
		settle(OFF + 3 * DET);
		check("recover", sup, 1'b1);
		// Fused image with a stored-bit error: safe mode
		@(posedge clk);
		fused <= 1'b1;
		fimg <= 8'h49;
		ferr <= 1'b1;
		do_reset();
		settle(80);
		check("safe_out", {sup, gnd, reg_hi}, 3'h0);
		check("safe_blink", ia ^ ib, 1'b1);
		// Good fused image: longest delay, then locked against writes
		@(posedge clk);
		ferr <= 1'b0;
		fimg <= 8'h78;
		do_reset();
		settle(50);
		check("delay_hold", {sup, ia}, 2'h0);
		settle(30);
		check("fused_run", {sup, ia, reg_hi}, 3'h7);
		wr_reg(8'h2A, 8'h3C);
		wr_reg(8'h36, 8'h96);
		// Image and select writes are refused once fused; the shadow
		// image keeps its reset value and the fused settings stay
		wr_reg(8'h07, 8'h5A);
		rd_reg(8'h07, r);
		check("locked", r, 8'h00);
		wr_reg(8'h08, 8'h00);
		rd_reg(8'h08, r);
		check("locked_ctl", r, 8'h01);
		wr_reg(8'h36, 8'h00);
		settle(4);
		check("fused_kept", {sup, reg_hi}, 2'h3);
		@(posedge clk);
		hot <= 1'b1;
		settle(6);
		check("hot", {sup, gnd, ia, ib, reg_on}, 5'h00);
		@(posedge clk);
		hot <= 1'b0;
		settle(6);
		check("cool", {sup, reg_on}, 2'h3);
		test_done();
	end

	// Watchdog against a hang
	initial
	begin
		repeat (100000) @(posedge clk);
		n_errors++;
		test_done();
	end
endmodule : tb_sensor_output_control_otp
`default_nettype wire
